/* core/ddrcp_top.sv */
// Command interpreter and clock-enable power control of a four-bank DDR memory.
// Assumes command pins arrive asynchronously and are synchronised here; data pins are
// sampled on the system clock, one beat per cycle.
// Notes on behaviour
// - Bank bits select one of four banks.
// - Clock enable low enters, high exits low power.
// - Masked bytes dropped, burst counter still advances.
// - Strobe driven on reads, input on writes.
// - Row, column, write pins encode eight commands.
// - Chip select high ignores command pins; clock enable still acts.
// - Auto-close bit precharges bank after burst.
// - Mode set picks normal or extended register.
// - Burst halt ends reads, never writes.
// - Read bursts from column; drivers float after.
// - Open command latches thirteen-bit row.
// - Close one bank, or all with bit.
// - Refresh uses internal counter, floats, precharges.
// - Self-refresh runs while clock enable low.
// - Power-down one cycle later, no refresh, loop on.
// - Entry and exit need no-op or deselect.
// - Commands accepted one cycle after power-down exit.
module ddrcp_top
  import ddrcp_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic BANK_SELECT_LO,
  input wire logic BANK_SELECT_HI,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic LOWER_BYTE_MASK,
  input wire logic UPPER_BYTE_MASK,
  input wire logic [DQ_W-1:0] DQ_IN,
  input wire logic [DQ_W-1:0] RD_DATA,
  input wire logic LOWER_BYTE_STROBE_IN,
  input wire logic UPPER_BYTE_STROBE_IN,
  output logic [DQ_W-1:0] DQ_OUT,
  output logic DQ_OE_N,
  output logic LOWER_BYTE_STROBE_OUT,
  output logic UPPER_BYTE_STROBE_OUT,
  output logic STROBE_OE_N,
  output logic [NBANK-1:0] BANK_OPEN,
  output logic [NBANK*ROW_W-1:0] BANK_ROW,
  output logic [BANK_W-1:0] BURST_BANK,
  output logic [COL_W-1:0] BURST_COL,
  output logic BURST_READ,
  output logic BURST_WRITE,
  output logic [DQ_W-1:0] WR_DATA,
  output logic [1:0] WR_BYTE_EN,
  output logic WR_STROBE_OK,
  output logic [ADDR_W-1:0] MODE_REG,
  output logic [ADDR_W-1:0] EXT_MODE_REG,
  output logic REFRESH_BUSY,
  output logic [BANK_W-1:0] REFRESH_BANK,
  output logic [ROW_W-1:0] REFRESH_ROW,
  output logic SELF_REFRESH,
  output logic POWER_DOWN,
  output logic DLL_ENABLE,
  output logic CMD_READY
);
  import ddrcp_pkg::*;

  typedef enum logic [2:0] {
    PW_ACTIVE, PW_PD_ENTRY, PW_POWERDOWN, PW_PD_EXIT, PW_SELF
  } ddrcp_pw_t;

  // Two-stage synchronisers for every control pin
  localparam int SYN_W = 7 + ADDR_W;
  logic [SYN_W-1:0] syn1_r, syn2_r;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      syn1_r <= {1'b0, 1'b1, 3'b111, 2'b00, {ADDR_W{1'b0}}};
      syn2_r <= {1'b0, 1'b1, 3'b111, 2'b00, {ADDR_W{1'b0}}};
    end else begin
      syn1_r <= {CKE, CS_N, RAS_N, CAS_N, WE_N, BANK_SELECT_LO, BANK_SELECT_HI, ADDR};
      syn2_r <= syn1_r;
    end
  end
  logic cke_s, cke_prev_r;
  assign cke_s = syn2_r[SYN_W-1];

  ddrcp_dec_if dif();
  ddrcp_decode u_dec (
    .cs_n(syn2_r[SYN_W-2]),
    .ras_n(syn2_r[SYN_W-3]),
    .cas_n(syn2_r[SYN_W-4]),
    .we_n(syn2_r[SYN_W-5]),
    .bank_select_lo(syn2_r[SYN_W-6]),
    .bank_select_hi(syn2_r[SYN_W-7]),
    .addr(syn2_r[ADDR_W-1:0]),
    .dec(dif.dec)
  );

  function automatic logic is_quiet(input ddrcp_cmd_t c);
    return (c == DDRCP_CMD_NOP) || (c == DDRCP_CMD_DESEL);
  endfunction

  ddrcp_pw_t pw_r, pw_nxt;
  logic [NBANK-1:0] open_r, open_nxt;
  logic [ROW_W-1:0] row_r [NBANK], row_nxt [NBANK];
  logic [BANK_W-1:0] bb_r, bb_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic rd_r, rd_nxt, wr_r, wr_nxt, ac_r, ac_nxt;
  logic [BURST_W-1:0] bcnt_r, bcnt_nxt;
  logic [ADDR_W-1:0] mr_r, mr_nxt, emr_r, emr_nxt;
  logic [CNT_W-1:0] rcnt_r, rcnt_nxt, wcnt_r, wcnt_nxt;
  logic [BANK_W-1:0] rbank_r, rbank_nxt;
  logic [ROW_W-1:0] rrow_r, rrow_nxt;
  logic accept;
  ddrcp_cmd_t cmd;

  assign cmd = dif.cmd;
  // Commands only act at full power, once exit waits and refresh have elapsed
  assign accept = (pw_r == PW_ACTIVE) && cke_prev_r && cke_s && (rcnt_r == CNT_ZERO);

  always_comb begin
    pw_nxt = pw_r;
    open_nxt = open_r;
    row_nxt = row_r;
    bb_nxt = bb_r;
    col_nxt = col_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    ac_nxt = ac_r;
    bcnt_nxt = bcnt_r;
    mr_nxt = mr_r;
    emr_nxt = emr_r;
    rcnt_nxt = rcnt_r;
    wcnt_nxt = wcnt_r;
    rbank_nxt = rbank_r;
    rrow_nxt = rrow_r;
    // Burst progress: counter runs whether or not bytes are masked
    if (rd_r || wr_r) begin
      bcnt_nxt = bcnt_r - BURST_ONE;
      col_nxt = col_r + COL_W'(1);
      if (bcnt_r == BURST_ONE) begin
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        if (ac_r) begin
          open_nxt[bb_r] = 1'b0;
        end
      end
    end
    if (rcnt_r != CNT_ZERO) begin
      rcnt_nxt = rcnt_r - CNT_ONE;
    end
    if (accept) begin
      unique case (cmd)
        DDRCP_CMD_HALT: begin
          if (rd_r) begin
            rd_nxt = 1'b0;
            bcnt_nxt = BURST_ZERO;
            if (ac_r) begin
              open_nxt[bb_r] = 1'b0;
            end
          end
        end
        DDRCP_CMD_READ, DDRCP_CMD_WRITE: begin
          if (open_r[dif.bank]) begin
            bb_nxt = dif.bank;
            col_nxt = dif.addr[COL_W-1:0];
            ac_nxt = dif.auto_close;
            rd_nxt = (cmd == DDRCP_CMD_READ);
            wr_nxt = (cmd == DDRCP_CMD_WRITE);
            bcnt_nxt = BURST_LEN;
          end
        end
        DDRCP_CMD_OPEN: begin
          open_nxt[dif.bank] = 1'b1;
          row_nxt[dif.bank] = dif.addr[ROW_W-1:0];
        end
        DDRCP_CMD_CLOSE: begin
          if (dif.auto_close) begin
            open_nxt = '0;
          end else begin
            open_nxt[dif.bank] = 1'b0;
          end
          if (dif.auto_close || dif.bank == bb_r) begin
            rd_nxt = 1'b0;
            wr_nxt = 1'b0;
          end
        end
        DDRCP_CMD_REFRESH: begin
          rd_nxt = 1'b0;
          wr_nxt = 1'b0;
          open_nxt = '0;
          if (cke_s) begin
            rcnt_nxt = RFC_CNT;
          end
        end
        DDRCP_CMD_MODE: begin
          if (dif.bank == DDRCP_BANK0 && !dif.auto_close) begin
            mr_nxt = dif.addr;
          end else if (dif.bank[BANK_W-1]) begin
            emr_nxt = dif.addr;
          end
        end
        default: begin
        end
      endcase
    end
    // Internal refresh counter steps on auto-refresh and each self-refresh pass
    if ((accept && cmd == DDRCP_CMD_REFRESH) || pw_r == PW_SELF) begin
      rrow_nxt = rrow_r + REF_ROW_ONE;
      if (rrow_r == {ROW_W{1'b1}}) begin
        rbank_nxt = rbank_r + BANK_W'(1);
      end
    end
    unique case (pw_r)
      PW_ACTIVE: begin
        if (cke_prev_r && !cke_s) begin
          if (cmd == DDRCP_CMD_REFRESH) begin
            pw_nxt = PW_SELF;
            open_nxt = '0;
            rd_nxt = 1'b0;
            wr_nxt = 1'b0;
          end else if (is_quiet(cmd)) begin
            pw_nxt = PW_PD_ENTRY;
            wcnt_nxt = PDN_CNT;
          end
        end
      end
      PW_PD_ENTRY: begin
        if (wcnt_r > CNT_ONE) begin
          wcnt_nxt = wcnt_r - CNT_ONE;
        end else begin
          pw_nxt = PW_POWERDOWN;
        end
      end
      PW_POWERDOWN, PW_SELF: begin
        if (cke_s && !cke_prev_r && is_quiet(cmd)) begin
          pw_nxt = PW_PD_EXIT;
          wcnt_nxt = PDX_CNT;
        end
      end
      PW_PD_EXIT: begin
        if (wcnt_r > CNT_ONE) begin
          wcnt_nxt = wcnt_r - CNT_ONE;
        end else begin
          pw_nxt = PW_ACTIVE;
        end
      end
      default: pw_nxt = PW_ACTIVE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pw_r <= PW_ACTIVE;
      cke_prev_r <= 1'b0;
      open_r <= '0;
      for (int i = 0; i < NBANK; i++) begin
        row_r[i] <= '0;
      end
      bb_r <= '0;
      col_r <= '0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      ac_r <= 1'b0;
      bcnt_r <= BURST_ZERO;
      mr_r <= '0;
      emr_r <= '0;
      rcnt_r <= CNT_ZERO;
      wcnt_r <= CNT_ZERO;
      rbank_r <= '0;
      rrow_r <= '0;
    end else begin
      pw_r <= pw_nxt;
      cke_prev_r <= cke_s;
      open_r <= open_nxt;
      row_r <= row_nxt;
      bb_r <= bb_nxt;
      col_r <= col_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      ac_r <= ac_nxt;
      bcnt_r <= bcnt_nxt;
      mr_r <= mr_nxt;
      emr_r <= emr_nxt;
      rcnt_r <= rcnt_nxt;
      wcnt_r <= wcnt_nxt;
      rbank_r <= rbank_nxt;
      rrow_r <= rrow_nxt;
    end
  end

  // Data path registers: read drive and masked write capture
  logic [DQ_W-1:0] dqo_r, dqo_nxt, wd_r, wd_nxt;
  logic [1:0] be_r, be_nxt;
  logic oe_n_r, oe_n_nxt, sok_r, sok_nxt;
  always_comb begin
    dqo_nxt = rd_r ? RD_DATA : dqo_r;
    oe_n_nxt = !rd_r;
    wd_nxt = wd_r;
    be_nxt = 2'b00;
    sok_nxt = 1'b0;
    if (wr_r) begin
      wd_nxt = DQ_IN;
      be_nxt = {!UPPER_BYTE_MASK, !LOWER_BYTE_MASK};
      sok_nxt = LOWER_BYTE_STROBE_IN && UPPER_BYTE_STROBE_IN;
    end
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dqo_r <= '0;
      oe_n_r <= 1'b1;
      wd_r <= '0;
      be_r <= 2'b00;
      sok_r <= 1'b0;
    end else begin
      dqo_r <= dqo_nxt;
      oe_n_r <= oe_n_nxt;
      wd_r <= wd_nxt;
      be_r <= be_nxt;
      sok_r <= sok_nxt;
    end
  end

  genvar g;
  for (g = 0; g < NBANK; g++) begin : g_row
    assign BANK_ROW[g*ROW_W +: ROW_W] = row_r[g];
  end

  assign DQ_OUT = dqo_r;
  assign DQ_OE_N = oe_n_r;
  // Strobe outputs sit high, without toggling, only while reads drive the bus
  assign LOWER_BYTE_STROBE_OUT = !oe_n_r;
  assign UPPER_BYTE_STROBE_OUT = !oe_n_r;
  assign STROBE_OE_N = oe_n_r;
  assign BANK_OPEN = open_r;
  assign BURST_BANK = bb_r;
  assign BURST_COL = col_r;
  assign BURST_READ = rd_r;
  assign BURST_WRITE = wr_r;
  assign WR_DATA = wd_r;
  assign WR_BYTE_EN = be_r;
  assign WR_STROBE_OK = sok_r;
  assign MODE_REG = mr_r;
  assign EXT_MODE_REG = emr_r;
  assign REFRESH_BUSY = (rcnt_r != CNT_ZERO) || (pw_r == PW_SELF);
  assign REFRESH_BANK = rbank_r;
  assign REFRESH_ROW = rrow_r;
  assign SELF_REFRESH = (pw_r == PW_SELF);
  assign POWER_DOWN = (pw_r == PW_POWERDOWN);
  assign DLL_ENABLE = 1'b1;
  assign CMD_READY = accept;
endmodule

/* core/ddrcp_pkg.sv */
// Package for the DDR command decode and power-state block: encodings and timing counts.
// Assumes a single system clock of 10 MHz; the refresh cycle count derives from it, while the entry and exit delays are given in cycles.
package ddrcp_pkg;
  localparam int CLK_NS = 100;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int ADDR_W = 15;
  localparam int NBANK = 4;
  localparam int BANK_W = 2;
  localparam int DQ_W = 16;
  localparam int BYTE_W = 8;
  localparam int AUTO_CLOSE_POS = 10;
  localparam int BURST_W = 4;
  localparam logic [BURST_W-1:0] BURST_LEN = 4'h0004;
  localparam int POWERDOWN_ENTRY_DELAY_CYC = 1;
  localparam int POWERDOWN_EXIT_DELAY_CYC = 1;
  localparam int REFRESH_CYCLE_TIME_NS = 300;
  localparam int RFC_CYC = (REFRESH_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] RFC_CNT = CNT_W'(RFC_CYC);
  localparam logic [CNT_W-1:0] PDX_CNT = CNT_W'(POWERDOWN_EXIT_DELAY_CYC);
  localparam logic [CNT_W-1:0] PDN_CNT = CNT_W'(POWERDOWN_ENTRY_DELAY_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [BURST_W-1:0] BURST_ZERO = 4'h0;
  localparam logic [BURST_W-1:0] BURST_ONE = 4'h1;
  localparam logic [ROW_W-1:0] REF_ROW_ONE = 13'h0001;

  typedef enum logic [3:0] {
    DDRCP_CMD_NOP, DDRCP_CMD_DESEL, DDRCP_CMD_HALT, DDRCP_CMD_READ, DDRCP_CMD_WRITE,
    DDRCP_CMD_OPEN, DDRCP_CMD_CLOSE, DDRCP_CMD_REFRESH, DDRCP_CMD_MODE, DDRCP_CMD_ILLEGAL
  } ddrcp_cmd_t;

  typedef enum logic [1:0] {
    DDRCP_BANK0, DDRCP_BANK1, DDRCP_BANK2, DDRCP_BANK3
  } ddrcp_bank_t;
endpackage

/* core/ddrcp_dec_if.sv */
// Interface carrying decoded command fields from the decoder to the control core.
// Assumes both ends sit on the same system clock.
interface ddrcp_dec_if;
  import ddrcp_pkg::*;
  ddrcp_cmd_t cmd;
  logic [BANK_W-1:0] bank;
  logic auto_close;
  logic [ADDR_W-1:0] addr;
  modport dec (output cmd, bank, auto_close, addr);
  modport core (input cmd, bank, auto_close, addr);
endinterface

/* core/ddrcp_decode.sv */
// Command decoder: turns synchronised pin levels into a command and bank.
// Assumes its inputs are already synchronised to the system clock.
module ddrcp_decode
  import ddrcp_pkg::*;
(
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic [ADDR_W-1:0] addr,
  ddrcp_dec_if.dec dec
);
  always_comb begin
    dec.bank = {bank_select_lo, bank_select_hi};
    dec.auto_close = addr[AUTO_CLOSE_POS];
    dec.addr = addr;
    if (cs_n) begin
      dec.cmd = DDRCP_CMD_DESEL;
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'b111: dec.cmd = DDRCP_CMD_NOP;
        3'b110: dec.cmd = DDRCP_CMD_HALT;
        3'b101: dec.cmd = DDRCP_CMD_READ;
        3'b100: dec.cmd = DDRCP_CMD_WRITE;
        3'b011: dec.cmd = DDRCP_CMD_OPEN;
        3'b010: dec.cmd = DDRCP_CMD_CLOSE;
        3'b001: dec.cmd = DDRCP_CMD_REFRESH;
        3'b000: dec.cmd = DDRCP_CMD_MODE;
        default: dec.cmd = DDRCP_CMD_ILLEGAL;
      endcase
    end
  end
endmodule

/* sim/ddrcp_asserts.sv */
// Port checker for the DDR command and power block.
// Assumes one clock domain and an asynchronous active-high reset.
module ddrcp_asserts
  import ddrcp_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CKE,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic LOWER_BYTE_MASK,
  input wire logic UPPER_BYTE_MASK,
  input wire logic [DQ_W-1:0] DQ_IN,
  input wire logic [DQ_W-1:0] RD_DATA,
  input wire logic LOWER_BYTE_STROBE_IN,
  input wire logic UPPER_BYTE_STROBE_IN,
  input wire logic [DQ_W-1:0] DQ_OUT,
  input wire logic DQ_OE_N,
  input wire logic LOWER_BYTE_STROBE_OUT,
  input wire logic STROBE_OE_N,
  input wire logic [NBANK-1:0] BANK_OPEN,
  input wire logic BURST_READ,
  input wire logic BURST_WRITE,
  input wire logic [DQ_W-1:0] WR_DATA,
  input wire logic [1:0] WR_BYTE_EN,
  input wire logic WR_STROBE_OK,
  input wire logic REFRESH_BUSY,
  input wire logic SELF_REFRESH,
  input wire logic POWER_DOWN,
  input wire logic DLL_ENABLE,
  input wire logic CMD_READY
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_strobe_dir;
    STROBE_OE_N == DQ_OE_N && LOWER_BYTE_STROBE_OUT == !DQ_OE_N;
  endproperty
  a_strobe_dir: assert property (p_strobe_dir) else $error("strobe direction wrong");
  property p_dq_float;
    DQ_OE_N == !$past(BURST_READ);
  endproperty
  a_dq_float: assert property (p_dq_float) else $error("data drivers wrong");
  property p_rd_data;
    $past(BURST_READ) |-> DQ_OUT == $past(RD_DATA);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read beat wrong");
  property p_byte_en;
    $past(BURST_WRITE) |-> WR_BYTE_EN == ~{$past(UPPER_BYTE_MASK), $past(LOWER_BYTE_MASK)};
  endproperty
  a_byte_en: assert property (p_byte_en) else $error("byte enable wrong");
  property p_wr_low;
    $past(BURST_WRITE) && !$past(LOWER_BYTE_MASK)
      |-> ((WR_DATA ^ $past(DQ_IN)) & 16'h00FF) == 16'h0000;
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("low write byte wrong");
  property p_strobe_ok;
    $past(BURST_WRITE)
      |-> WR_STROBE_OK == ($past(LOWER_BYTE_STROBE_IN) && $past(UPPER_BYTE_STROBE_IN));
  endproperty
  a_strobe_ok: assert property (p_strobe_ok) else $error("write strobe flag wrong");
  property p_pd_quiet;
    POWER_DOWN |-> !REFRESH_BUSY && DLL_ENABLE && !CMD_READY;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("power-down state wrong");
  property p_pd_hold;
    POWER_DOWN && $past(POWER_DOWN) |-> $stable(BANK_OPEN);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("banks moved in power-down");
  property p_self;
    SELF_REFRESH |-> REFRESH_BUSY && BANK_OPEN == 4'h0 && !CMD_READY;
  endproperty
  a_self: assert property (p_self) else $error("self-refresh state wrong");
  // Entry and exit need the enable level to settle through the synchroniser first
  property p_pd_entry;
    !POWER_DOWN && CMD_READY && BANK_OPEN == 4'h0 && $fell(CKE) && RAS_N && CAS_N && WE_N
      ##1 (!CKE && RAS_N && CAS_N && WE_N) [*3] |-> ##[0:4] POWER_DOWN;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");
  property p_pd_exit;
    POWER_DOWN && $rose(CKE) && RAS_N && CAS_N && WE_N
      ##1 (CKE && RAS_N && CAS_N && WE_N) [*3] |-> ##[0:4] !POWER_DOWN;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down not left");
endmodule
bind ddrcp_top ddrcp_asserts u_chk (.CLK_SYS, .RST, .CKE, .RAS_N, .CAS_N, .WE_N,
  .LOWER_BYTE_MASK, .UPPER_BYTE_MASK, .DQ_IN, .RD_DATA, .LOWER_BYTE_STROBE_IN,
  .UPPER_BYTE_STROBE_IN, .DQ_OUT, .DQ_OE_N, .LOWER_BYTE_STROBE_OUT, .STROBE_OE_N,
  .BANK_OPEN, .BURST_READ, .BURST_WRITE, .WR_DATA, .WR_BYTE_EN, .WR_STROBE_OK,
  .REFRESH_BUSY, .SELF_REFRESH, .POWER_DOWN, .DLL_ENABLE, .CMD_READY);

/* sim/ddrcp_ctrl_model.sv */
// Memory controller model: command, bank, address and clock-enable pins.
// Assumes pins move 10 ns after the rising edge; the bench calls its tasks.
module ddrcp_ctrl_model
  import ddrcp_pkg::*;
(
  input wire logic clk,
  output logic cke,
  output logic [3:0] cmd_n,
  output logic [1:0] ba,
  output logic [ADDR_W-1:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cke = 1'b0;
    cmd_n = 4'h7;
    ba = 2'h0;
    addr = 15'h0000;
  end
  // Released bank and address show the inverse and the command returns to no-op, so a stale value never decodes by luck
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
    @(posedge clk);
    #10;
    cmd_n = c;
    ba = b;
    addr = a;
    @(posedge clk);
    #10;
    cmd_n = 4'h7;
    ba = ~b;
    addr = ~a;
  endtask
  task automatic set_cke(input logic v, input logic [3:0] c);
    @(posedge clk);
    #10;
    cke = v;
    cmd_n = c;
    @(posedge clk);
    #10;
    cmd_n = 4'h7;
    repeat (10) @(posedge clk);
    #10;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
endmodule

/* sim/ddrcp_test.sv */
// Bench for the DDR command and power block: reset and deselect check, bank-open table, then hand cases.
// Assumes the controller model drives command pins; the bench drives data pins.
module ddrcp_test
  import ddrcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [1:0] ba;
    logic [ROW_W-1:0] row;
    logic [1:0] bank;
  } ddrcp_open_t;
  ddrcp_open_t tab [4] = '{'{2'h0, 13'h0123, 2'h0}, '{2'h1, 13'h1FFF, 2'h1},
    '{2'h2, 13'h0000, 2'h2}, '{2'h3, 13'h1555, 2'h3}};
  logic clk_sys, rst, lo_mask, up_mask, lo_stb, up_stb, cke, dq_oe_n, burst_read, burst_write;
  logic refresh_busy, self_ref, power_down, cmd_ready, up_stb_out, wr_stb_ok, dll_en;
  logic [3:0] cmd_n, bank_open;
  logic [1:0] ba, wr_byte_en, burst_bank, refresh_bank;
  logic [ROW_W-1:0] refresh_row;
  logic [ADDR_W-1:0] addr, mode_reg, ext_mode_reg;
  logic [DQ_W-1:0] dq_in, rd_data;
  logic [NBANK*ROW_W-1:0] bank_row;
  logic [COL_W-1:0] burst_col;
  int bad_count = 0;
  int num_checks = 0;
  int rd_beats = 0;
  int wr_beats = 0;
  ddrcp_ctrl_model ctl (.clk(clk_sys), .cke(cke), .cmd_n(cmd_n), .ba(ba), .addr(addr));
  ddrcp_top dut (
    .CLK_SYS(clk_sys), .RST(rst), .CKE(cke), .CS_N(cmd_n[3]), .RAS_N(cmd_n[2]),
    .CAS_N(cmd_n[1]), .WE_N(cmd_n[0]), .BANK_SELECT_LO(ba[1]), .BANK_SELECT_HI(ba[0]),
    .ADDR(addr), .LOWER_BYTE_MASK(lo_mask), .UPPER_BYTE_MASK(up_mask), .DQ_IN(dq_in),
    .RD_DATA(rd_data), .LOWER_BYTE_STROBE_IN(lo_stb), .UPPER_BYTE_STROBE_IN(up_stb),
    .DQ_OUT(), .DQ_OE_N(dq_oe_n), .LOWER_BYTE_STROBE_OUT(), .UPPER_BYTE_STROBE_OUT(up_stb_out),
    .STROBE_OE_N(), .BANK_OPEN(bank_open), .BANK_ROW(bank_row), .BURST_BANK(burst_bank),
    .BURST_COL(burst_col), .BURST_READ(burst_read), .BURST_WRITE(burst_write), .WR_DATA(),
    .WR_BYTE_EN(wr_byte_en), .WR_STROBE_OK(wr_stb_ok), .MODE_REG(mode_reg),
    .EXT_MODE_REG(ext_mode_reg), .REFRESH_BUSY(refresh_busy), .REFRESH_BANK(refresh_bank),
    .REFRESH_ROW(refresh_row), .SELF_REFRESH(self_ref), .POWER_DOWN(power_down),
    .DLL_ENABLE(dll_en), .CMD_READY(cmd_ready));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    #10;
    dq_in = dq_in + 16'h1111;
    rd_data = ~dq_in;
    if (burst_read === 1'b1) rd_beats++;
    if (burst_write === 1'b1) wr_beats++;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_for(ref logic sig, input logic val);
    int n;
    for (n = 0; n < 60 && sig !== val; n++) begin
      @(posedge clk_sys);
      #10;
    end
    if (n < 60) begin
      chk(sig, val);
    end else begin
      bad_count++;
      $display("[FAIL] %0t wait timed out", $time);
      tally_and_finish();
    end
  endtask
  task automatic done(input string s);
    $display("%0t test %s end", $time, s);
  endtask
  initial begin
    rst = 1'b1;
    {lo_mask, up_mask, lo_stb, up_stb} = 4'h0;
    dq_in = 16'h0000;
    rd_data = 16'hFFFF;
    repeat (4) @(posedge clk_sys);
    #10;
    rst = 1'b0;
    chk(dq_oe_n, 1'b1);
    chk(bank_open, 4'h0);
    ctl.set_cke(1'b1, 4'h7);
    wait_for(cmd_ready, 1'b1);
    ctl.issue(4'hB, 2'h0, 15'h0000);
    ctl.tick(4);
    chk(bank_open, 4'h0);
    done("reset and deselect");
    foreach (tab[i]) begin
      ctl.issue(4'h3, tab[i].ba, {2'h0, tab[i].row});
      ctl.tick(4);
      chk(bank_open[tab[i].bank], 1'b1);
      chk(bank_row[ROW_W*tab[i].bank +: ROW_W], tab[i].row);
    end
    done("open table");
    ctl.issue(4'h5, 2'h1, 15'h0005);
    wait_for(burst_read, 1'b1);
    chk(burst_col, 10'h005);
    chk(burst_bank, 2'h1);
    wait_for(dq_oe_n, 1'b0);
    chk(up_stb_out, 1'b1);
    wait_for(burst_read, 1'b0);
    wait_for(dq_oe_n, 1'b1);
    chk(rd_beats, BURST_LEN);
    rd_beats = 0;
    ctl.issue(4'h5, 2'h1, 15'h0008);
    ctl.issue(4'h6, 2'h0, 15'h0000);
    ctl.tick(10);
    chk(rd_beats < 4, 1'b1);
    done("read and halt");
    {lo_mask, lo_stb, up_stb} = 3'h7;
    wr_beats = 0;
    ctl.issue(4'h4, 2'h1, 15'h0000);
    ctl.issue(4'h6, 2'h0, 15'h0000);
    wait_for(burst_write, 1'b0);
    chk(wr_byte_en, 2'h2);
    chk(wr_stb_ok, 1'b1);
    chk(wr_beats, BURST_LEN);
    lo_mask = 1'b0;
    done("masked write");
    ctl.issue(4'h5, 2'h2, 15'h0400);
    ctl.tick(12);
    chk(bank_open, 4'hB);
    ctl.issue(4'h2, 2'h3, 15'h0000);
    ctl.tick(4);
    chk(bank_open, 4'h3);
    ctl.issue(4'h2, 2'h0, 15'h0400);
    ctl.tick(4);
    chk(bank_open, 4'h0);
    done("close");
    ctl.issue(4'h0, 2'h0, 15'h0062);
    ctl.issue(4'h0, 2'h2, 15'h0001);
    ctl.issue(4'h0, 2'h0, 15'h0400);
    ctl.tick(4);
    chk(mode_reg, 15'h0062);
    chk(ext_mode_reg, 15'h0001);
    done("mode set");
    ctl.issue(4'h1, 2'h0, 15'h0000);
    wait_for(refresh_busy, 1'b1);
    chk(dq_oe_n, 1'b1);
    wait_for(refresh_busy, 0);
    chk(bank_open, 4'h0);
    chk(refresh_row, 13'h0001);
    chk(refresh_bank, 2'h0);
    ctl.tick(RFC_CYC);
    done("refresh");
    ctl.set_cke(1'b0, 4'h7);
    chk(power_down, 1'b1);
    chk(dll_en, 1'b1);
    ctl.issue(4'h3, 2'h0, 15'h0000);
    ctl.tick(4);
    chk(bank_open, 4'h0);
    ctl.set_cke(1'b1, 4'hF);
    chk(power_down, 1'b0);
    chk(cmd_ready, 1'b1);
    done("power-down");
    ctl.set_cke(1'b0, 4'h1);
    chk(self_ref, 1'b1);
    ctl.tick(30);
    chk(refresh_busy, 1'b1);
    ctl.set_cke(1'b1, 4'h7);
    chk(self_ref, 1'b0);
    ctl.issue(4'h1, 2'h0, 15'h0000);
    wait_for(refresh_busy, 1'b1);
    done("self-refresh");
    tally_and_finish();
  end
endmodule
